// ---- shared/see_params.svh ----
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// Array geometry
`define SEE_PAGES         128
`define SEE_PAGE_BYTES    16
`define SEE_DEPTH         2048
`define SEE_ADDR_W        11
`define SEE_COL_W         4
`define SEE_ROW_W         7

// Frame layout
`define SEE_LAST_DATA_BIT 4'h7
`define SEE_ACK_BIT       4'h8
`define SEE_RECOVER_BITS  18

// System clock
`define SEE_SYS_MHZ       40
`define SEE_SYS_PERIOD_NS 25

// Self-timed programming, longest time rounds down
`define SEE_PROG_TIME_US  5000
`define SEE_PROG_CYC      (`SEE_PROG_TIME_US * `SEE_SYS_MHZ)

// Host serial clock quarter period
`define SEE_SCL_QTR_NS    625
`define SEE_QTR_CYC       (`SEE_SCL_QTR_NS / `SEE_SYS_PERIOD_NS)

`endif

// ---- shared/see_pkg.sv ----
package see_pkg;

  // Host byte-level commands
  typedef enum logic [2:0] {
    SEE_OP_START,
    SEE_OP_STOP,
    SEE_OP_WRITE,
    SEE_OP_READ,
    SEE_OP_RECOVER
  } see_op_t;

  // Device protocol states
  typedef enum logic [2:0] {
    D_IDLE,
    D_DEVADDR,
    D_WADDR,
    D_WDATA,
    D_READ,
    D_PROG
  } see_dst_t;

  // Host sequencer states
  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_BIT,
    H_STOP
  } see_hst_t;

endpackage : see_pkg

// ---- shared/see_if.sv ----
interface see_if;
  logic scl;          // Serial clock, made by the host end
  logic sda_host_oe;  // Host pulls data low
  logic sda_dev_oe;   // Device pulls data low
  logic sda;          // Resolved data level

  // Open-drain wire with pull-up
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport dev (input scl, input sda, output sda_dev_oe);
  modport host (output scl, output sda_host_oe, input sda);
endinterface : see_if

// ---- src/see_sync.sv ----
module see_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by second

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle-high level of the link pins, so no false edge after reset
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : see_sync

// ---- src/see_device.sv ----
// Overview of operation
// - Sample on SCL rise, drive after fall
// - Data line only pulled low or released
// - Write protect high blocks all programming
// - 128 pages of 16 bytes, 11-bit address
// - Controller changes data only while clock low
// - Data fall with clock high is START
// - Data rise with clock high is STOP
// - Acknowledge each byte on ninth clock
// - Standby after reset, read stop, programming
// - START, eighteen ones, START restores idle
// - Class code match acknowledged, else standby
// - Eighth address bit selects read or write
// - No chip-select bits, one device per bus
// - Byte write acknowledged on 9, 18, 27
// - STOP after write starts timed programming
// - Page write accepts one to sixteen bytes
// - Only column bits increment, wrapping at sixteen
// - No acknowledge while programming, enables polling
// - Partial pages program only loaded bytes
// - Programming erases targeted bytes automatically
// - Counter holds last address plus one
// - Acked read continues, counter wraps at top
// - Random read is dummy write then read
`include "see_params.svh"

module see_device #(
  parameter int unsigned PROG_CYC   = `SEE_PROG_CYC,
  parameter logic [3:0]  CLASS_CODE = 4'h5  // Arbitrary value
) (
  // System clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Two-wire link
  see_if.dev        link,
  // Pins and status
  input  wire logic wp,
  output logic      prog_busy,
  output logic      standby
);

  // Synchronised pins
  logic scl_s;  // Clock level
  logic sda_s;  // Data level
  logic wp_s;   // Write protect level

  // Previous levels for edge and condition detection
  logic scl_p_r;
  logic sda_p_r;

  // Link-domain registers
  logic [7:0] rx_sh_r;  // Shift register, clocked by SCL rise
  logic       sda_oe_r; // Pull-down enable, clocked by SCL fall

  // System-domain protocol state
  see_pkg::see_dst_t       state_r;    // Protocol state
  logic [3:0]              bit_cnt_r;  // Clock number in frame, 0..8
  logic                    drive_low_r; // Level for next falling edge
  logic [7:0]              tx_r;       // Byte being sent
  logic [`SEE_ADDR_W-1:0]  addr_r;     // Address counter
  logic [31:0]             prog_cnt_r; // Programming timer
  logic [`SEE_PAGE_BYTES-1:0] page_vld_r; // Loaded columns
  logic [7:0] page_buf_r [`SEE_PAGE_BYTES]; // Page latch
  logic [7:0] mem_r [`SEE_DEPTH];         // Array storage
  logic       prog_busy_r;
  logic       standby_r;

  // Decoded events
  logic       scl_rise;
  logic       start_ev;
  logic       stop_ev;
  logic       active;
  logic       bit_rise;
  logic       byte_end;
  logic       ack_end;
  logic       addr_match;
  logic       host_ack;
  logic       prog_done;
  logic [7:0] rd_byte;

  // Pins cross into the system clock through two flops each
  see_sync #(.WIDTH(3)) u_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     ({link.scl, link.sda, wp}),
    .q     ({scl_s, sda_s, wp_s})
  );

  // Previous synchronised levels
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  // Data is latched on the link clock's rising edge; the system side
  // reads it only after the synchronised rise, when it is long stable
  always_ff @(posedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      rx_sh_r <= 8'h00;
    end else begin
      rx_sh_r <= {rx_sh_r[6:0], link.sda};
    end
  end

  // Output moves only on the falling edge; drive_low_r changes while
  // SCL is high, so it is stable whenever this flop samples it
  always_ff @(negedge link.scl or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= drive_low_r;
    end
  end

  // Open drain: enable only pulls low, never drives high
  assign link.sda_dev_oe = sda_oe_r;

  // Conditions on the wire
  always_comb begin
    scl_rise   = scl_s & ~scl_p_r;
    start_ev   = scl_s & scl_p_r & sda_p_r & ~sda_s;
    stop_ev    = scl_s & scl_p_r & ~sda_p_r & sda_s;
    active     = (state_r != see_pkg::D_IDLE) && (state_r != see_pkg::D_PROG);
    bit_rise   = scl_rise & active;
    byte_end   = bit_rise & (bit_cnt_r == `SEE_LAST_DATA_BIT);
    ack_end    = bit_rise & (bit_cnt_r == `SEE_ACK_BIT);
    // Class code only, no chip-select bits compared
    addr_match = (rx_sh_r[7:4] == CLASS_CODE);
    host_ack   = ~rx_sh_r[0];
    prog_done  = (state_r == see_pkg::D_PROG) && (prog_cnt_r == PROG_CYC - 1);
    rd_byte    = mem_r[addr_r];
  end

  // Protocol sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= see_pkg::D_IDLE;
      bit_cnt_r   <= 4'h0;
      drive_low_r <= 1'b0;
    end else begin
      case (state_r)
        see_pkg::D_PROG: begin
          // All wire activity ignored until the cycle ends
          if (prog_done) begin
            state_r <= see_pkg::D_IDLE;
          end
        end
        default: begin
          if (start_ev) begin
            // Any START, including repeated or recovery, restarts framing
            state_r     <= see_pkg::D_DEVADDR;
            bit_cnt_r   <= 4'h0;
            drive_low_r <= 1'b0;
          end else if (stop_ev) begin
            drive_low_r <= 1'b0;
            // Write-protect blocks programming, reads untouched
            if (state_r == see_pkg::D_WDATA && |page_vld_r && !wp_s) begin
              state_r <= see_pkg::D_PROG;
            end else begin
              state_r <= see_pkg::D_IDLE;
            end
          end else if (bit_rise) begin
            bit_cnt_r <= (bit_cnt_r == `SEE_ACK_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
            case (state_r)
              see_pkg::D_DEVADDR: begin
                if (byte_end && addr_match) begin
                  drive_low_r <= 1'b1;
                end else if (byte_end) begin
                  state_r <= see_pkg::D_IDLE;
                end else if (ack_end && rx_sh_r[1]) begin
                  // Direction bit was shifted one place by the ack clock
                  state_r     <= see_pkg::D_READ;
                  drive_low_r <= ~rd_byte[7];
                end else if (ack_end) begin
                  state_r     <= see_pkg::D_WADDR;
                  drive_low_r <= 1'b0;
                end
              end
              see_pkg::D_WADDR, see_pkg::D_WDATA: begin
                if (byte_end) begin
                  drive_low_r <= 1'b1;
                end else if (ack_end) begin
                  state_r     <= see_pkg::D_WDATA;
                  drive_low_r <= 1'b0;
                end
              end
              see_pkg::D_READ: begin
                if (ack_end && host_ack) begin
                  drive_low_r <= ~rd_byte[7];
                end else if (ack_end) begin
                  // No acknowledge ends the read
                  state_r     <= see_pkg::D_IDLE;
                  drive_low_r <= 1'b0;
                end else if (byte_end) begin
                  drive_low_r <= 1'b0;  // Release for controller ack
                end else begin
                  drive_low_r <= ~tx_r[3'h6 - bit_cnt_r[2:0]];
                end
              end
              default: begin
                drive_low_r <= 1'b0;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Read byte latch and address counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= '0;
      tx_r   <= 8'h00;
    end else if (state_r == see_pkg::D_DEVADDR && byte_end && addr_match && !rx_sh_r[0]) begin
      addr_r[10:8] <= rx_sh_r[3:1];
    end else if (state_r == see_pkg::D_WADDR && byte_end) begin
      addr_r[7:0] <= rx_sh_r;
    end else if (state_r == see_pkg::D_WDATA && byte_end) begin
      // Row stays, column wraps within the page
      addr_r[`SEE_COL_W-1:0] <= addr_r[`SEE_COL_W-1:0] + 4'h1;
    end else if (ack_end && ((state_r == see_pkg::D_DEVADDR && rx_sh_r[1])
                 || (state_r == see_pkg::D_READ && host_ack))) begin
      tx_r   <= rd_byte;
      addr_r <= addr_r + 11'h001;
    end
  end

  // Page latch contents
  always_ff @(posedge sys_clk) begin
    if (state_r == see_pkg::D_WDATA && byte_end) begin
      page_buf_r[addr_r[`SEE_COL_W-1:0]] <= rx_sh_r;
    end
  end

  // Loaded-column flags, a new START abandons an unfinished load
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_vld_r <= '0;
    end else if (prog_done || (start_ev && active) || (start_ev && state_r == see_pkg::D_IDLE)) begin
      page_vld_r <= '0;
    end else if (state_r == see_pkg::D_WDATA && byte_end) begin
      page_vld_r[addr_r[`SEE_COL_W-1:0]] <= 1'b1;
    end
  end

  // Self-timed programming cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_cnt_r <= 32'h0;
    end else if (state_r == see_pkg::D_PROG) begin
      prog_cnt_r <= prog_cnt_r + 32'h1;
    end else begin
      prog_cnt_r <= 32'h0;
    end
  end

  // Commit at the end of the cycle; each loaded byte is replaced whole,
  // so no separate erase step exists
  always_ff @(posedge sys_clk) begin
    if (prog_done) begin
      for (int i = 0; i < `SEE_PAGE_BYTES; i++) begin
        if (page_vld_r[i]) begin
          mem_r[{addr_r[`SEE_ADDR_W-1:`SEE_COL_W], i[`SEE_COL_W-1:0]}] <= page_buf_r[i];
        end
      end
    end
  end

  // Status outputs, one cycle behind the state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_busy_r <= 1'b0;
      standby_r   <= 1'b1;
    end else begin
      prog_busy_r <= (state_r == see_pkg::D_PROG);
      standby_r   <= (state_r == see_pkg::D_IDLE);
    end
  end

  assign prog_busy = prog_busy_r;
  assign standby   = standby_r;

endmodule : see_device

// ---- src/see_host.sv ----
`include "see_params.svh"

module see_host (
  // System clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // Two-wire link
  see_if.host                    link,
  // Command side
  input  wire logic              cmd_valid,
  input  wire see_pkg::see_op_t  cmd_op,
  input  wire logic [7:0]        cmd_data,
  input  wire logic              cmd_ack,
  output logic                   cmd_ready,
  // Response side
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_nack
);

  see_pkg::see_hst_t state_r;   // Sequencer state
  see_pkg::see_op_t  op_r;      // Command in progress
  logic [7:0]        tx_r;      // Outgoing bits, MSB first
  logic [7:0]        rx_r;      // Incoming bits
  logic              ack_r;     // Pull low on read ack clock
  logic              nack_r;    // Level seen on ninth clock
  logic              rec_r;     // Recovery still needs its bit burst
  logic [1:0]        q_r;       // Quarter of the bit period
  logic [7:0]        qcnt_r;    // Cycles within the quarter
  logic [4:0]        bidx_r;    // Bit within the frame
  logic              scl_r;
  logic              sda_oe_r;
  logic              cmd_ready_r;
  logic              rsp_valid_r;
  logic [7:0]        rsp_data_r;
  logic              rsp_nack_r;
  logic              sda_s;     // Synchronised data level
  logic              tick;      // End of a quarter
  logic              drv;       // Pull-down wanted for this bit
  logic [4:0]        last_bit;  // Final bit index of the burst

  // Data line is a pin from outside the clock domain
  see_sync #(.WIDTH(1)) u_sync (
    .clk   (sys_clk),
    .rst_b (rst_b),
    .d     (link.sda),
    .q     (sda_s)
  );

  always_comb begin
    tick     = (qcnt_r == 8'(`SEE_QTR_CYC - 1));
    last_bit = (op_r == see_pkg::SEE_OP_RECOVER) ? 5'(`SEE_RECOVER_BITS - 1) : 5'h08;
    // Read ack clock carries our own ack, all else follows the byte
    drv      = (op_r == see_pkg::SEE_OP_READ && bidx_r == 5'h08) ? ack_r : ~tx_r[7];
  end

  // Quarter timer, free only while a command runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      qcnt_r <= 8'h00;
    end else if (state_r == see_pkg::H_IDLE || tick) begin
      qcnt_r <= 8'h00;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end

  // Sequencer; the serial clock is divided down from sys_clk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= see_pkg::H_IDLE;
      op_r        <= see_pkg::SEE_OP_STOP;
      tx_r        <= 8'hff;
      rx_r        <= 8'h00;
      ack_r       <= 1'b0;
      nack_r      <= 1'b0;
      rec_r       <= 1'b0;
      q_r         <= 2'h0;
      bidx_r      <= 5'h00;
      scl_r       <= 1'b1;
      sda_oe_r    <= 1'b0;
      cmd_ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 8'h00;
      rsp_nack_r  <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        see_pkg::H_IDLE: begin
          if (cmd_valid && cmd_ready_r) begin
            cmd_ready_r <= 1'b0;
            op_r        <= cmd_op;
            tx_r        <= (cmd_op == see_pkg::SEE_OP_WRITE) ? cmd_data : 8'hff;
            ack_r       <= cmd_ack;
            rec_r       <= (cmd_op == see_pkg::SEE_OP_RECOVER);
            q_r         <= 2'h0;
            bidx_r      <= 5'h00;
            case (cmd_op)
              see_pkg::SEE_OP_START, see_pkg::SEE_OP_RECOVER: state_r <= see_pkg::H_START;
              see_pkg::SEE_OP_STOP: state_r <= see_pkg::H_STOP;
              default: state_r <= see_pkg::H_BIT;
            endcase
          end
        end
        see_pkg::H_START: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b1;
              default: begin
                scl_r <= 1'b0;
                if (rec_r) begin
                  // Eighteen released clocks, then a second START
                  rec_r   <= 1'b0;
                  state_r <= see_pkg::H_BIT;
                end else begin
                  state_r     <= see_pkg::H_IDLE;
                  cmd_ready_r <= 1'b1;
                  rsp_valid_r <= 1'b1;
                end
              end
            endcase
          end
        end
        see_pkg::H_STOP: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b0;
              default: begin
                state_r     <= see_pkg::H_IDLE;
                cmd_ready_r <= 1'b1;
                rsp_valid_r <= 1'b1;
              end
            endcase
          end
        end
        see_pkg::H_BIT: begin
          if (tick) begin
            q_r <= q_r + 2'h1;
            case (q_r)
              2'h0: sda_oe_r <= drv;
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (bidx_r < 5'h08) begin
                  rx_r <= {rx_r[6:0], sda_s};
                end else begin
                  nack_r <= sda_s;
                end
              end
              default: begin
                scl_r <= 1'b0;
                tx_r  <= {tx_r[6:0], 1'b1};
                if (bidx_r == last_bit && op_r == see_pkg::SEE_OP_RECOVER) begin
                  state_r <= see_pkg::H_START;
                end else if (bidx_r == last_bit) begin
                  state_r     <= see_pkg::H_IDLE;
                  cmd_ready_r <= 1'b1;
                  rsp_valid_r <= 1'b1;
                  rsp_data_r  <= rx_r;
                  rsp_nack_r  <= nack_r;
                end else begin
                  bidx_r <= bidx_r + 5'h01;
                end
              end
            endcase
          end
        end
        default: begin
          state_r <= see_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.scl         = scl_r;
  assign link.sda_host_oe = sda_oe_r;
  assign cmd_ready        = cmd_ready_r;
  assign rsp_valid        = rsp_valid_r;
  assign rsp_data         = rsp_data_r;
  assign rsp_nack         = rsp_nack_r;

endmodule : see_host

// ---- dv/see_chk.sv ----
module see_chk #(
  parameter int PROG_CYC = 3000  // Programming length in cycles
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Link wires
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda,
  // Device pins
  input wire logic wp,
  input wire logic prog_busy,
  input wire logic standby
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUSY_LO = PROG_CYC - 1;  // One cycle of status lag allowed
  localparam int BUSY_HI = PROG_CYC + 1;
  int busy_cnt_r;                         // Length of current busy run

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Busy run length; a counter avoids a huge repetition
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= prog_busy ? busy_cnt_r + 1 : 0;
    end
  end

  // Past reset level guards against values from before a reset
  AST_EDGE: assert property ($past(rst_b) && $changed(sda_dev_oe) |-> !scl)
    else $error("device data moved while clock high");
  AST_BUSY_QUIET: assert property (prog_busy |-> !sda_dev_oe)
    else $error("device drove data while programming");
  AST_BUSY_AWAKE: assert property (prog_busy |-> !standby)
    else $error("standby shown while programming");
  AST_PROG_LEN: assert property ($past(rst_b) && $fell(prog_busy) |-> busy_cnt_r >= BUSY_LO && busy_cnt_r <= BUSY_HI)
    else $error("programming run has wrong length");
  AST_PROG_STOP: assert property ($rose(prog_busy) |-> scl && sda)
    else $error("programming began without a stop");
  AST_WP_BLOCK: assert property (wp && $past(wp, 8) |-> !$rose(prog_busy))
    else $error("programming began while protected");
  AST_ACK_HOLD: assert property ($rose(sda_dev_oe) |-> ##[1:60] $rose(scl) ##1 sda_dev_oe)
    else $error("device let go of data before clock high");
  AST_IDLE_QUIET: assert property (standby |-> !sda_dev_oe)
    else $error("device drove data in standby");
  AST_HOST_STABLE: assert property ($changed(sda_host_oe) |-> !scl || $past(scl, 20))
    else $error("controller moved data inside a clock high phase");
endmodule : see_chk

// ---- dv/serial_eeprom_slave_tb.sv ----
module serial_eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PROG_CYC = 3000;   // Short programming keeps the run brief
  localparam logic [3:0] CLASS    = 4'h5;   // Arbitrary value
  localparam int         LIMIT    = 100000; // Cycle ceiling for the run
  // Bench signals
  logic             sys_clk, rst_b, wp, cmd_valid, cmd_ack;
  see_pkg::see_op_t cmd_op;
  logic [7:0]       cmd_data, rsp_data;
  logic             cmd_ready, rsp_valid, rsp_nack, prog_busy, standby;
  int               fail_count, checks, cyc;
  logic [7:0]       mem [0:2047];           // Expected array contents
  see_if link_if ();

  see_device #(.PROG_CYC(PROG_CYC), .CLASS_CODE(CLASS)) see_device_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(link_if.dev), .wp(wp), .prog_busy(prog_busy), .standby(standby));
  see_host see_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_if.host), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  see_chk #(.PROG_CYC(PROG_CYC)) chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .scl(link_if.scl),
    .sda_host_oe(link_if.sda_host_oe), .sda_dev_oe(link_if.sda_dev_oe), .sda(link_if.sda), .wp(wp),
    .prog_busy(prog_busy), .standby(standby));

  // Clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  // One host command, held until taken, then wait for its answer
  task automatic do_cmd(input see_pkg::see_op_t op, input logic [7:0] d, input logic a);
    int n = 0;
    @(posedge sys_clk);
    #2;
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    cmd_ack   = a;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
    #2;
    cmd_valid = 1'b0;
    cmp_bit("ready low", 1'b0, cmd_ready);
    while (rsp_valid !== 1'b1 && n < 2100) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    cmp_bit("answer", 1'b1, rsp_valid);
    cmp_bit("ready high", 1'b1, cmd_ready);
  endtask : do_cmd

  task automatic bus_op(input see_pkg::see_op_t op);
    do_cmd(op, 8'h00, 1'b0);
  endtask : bus_op

  task automatic wr(input logic [7:0] d, input logic exp_nack);
    do_cmd(see_pkg::SEE_OP_WRITE, d, 1'b0);
    cmp_bit("write ack", exp_nack, rsp_nack);
  endtask : wr

  task automatic rd(input logic ack, input logic [7:0] exp);
    do_cmd(see_pkg::SEE_OP_READ, 8'h00, ack);
    cmp_byte("read data", exp, rsp_data);
  endtask : rd

  // Start, address word, low address byte
  task automatic set_ptr(input logic [10:0] a);
    bus_op(see_pkg::SEE_OP_START);
    wr({CLASS, a[10:8], 1'b0}, 1'b0);
    wr(a[7:0], 1'b0);
  endtask : set_ptr

  // Page load; model keeps the row and wraps the column
  task automatic write_run(input logic [10:0] a, input int n, input logic [7:0] base);
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      wr(base + 8'(i), 1'b0);
      if (!wp) begin
        mem[{a[10:4], 4'(a[3:0] + 4'(i))}] = base + 8'(i);
      end
    end
    bus_op(see_pkg::SEE_OP_STOP);
  endtask : write_run

  // Busy check, then poll with address words until acknowledged
  task automatic wait_prog();
    int   tries = 0;
    logic nack  = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    cmp_bit("busy", 1'b1, prog_busy);
    cmp_bit("standby", 1'b0, standby);
    while (nack && tries < 10) begin
      bus_op(see_pkg::SEE_OP_START);
      do_cmd(see_pkg::SEE_OP_WRITE, {CLASS, 4'h0}, 1'b0);
      nack = rsp_nack;
      if (tries == 0) cmp_bit("poll nack", 1'b1, nack);
      bus_op(see_pkg::SEE_OP_STOP);
      tries++;
    end
    cmp_bit("poll ack", 1'b0, nack);
  endtask : wait_prog

  // Byte write, then a page load that wraps its column
  task automatic t_write();
    write_run(11'h000, 1, 8'h3c);
    wait_prog();
    write_run(11'h7fe, 18, 8'h40);
    wait_prog();
  endtask : t_write

  task automatic t_protect();
    wp = 1'b1;
    write_run(11'h7f5, 1, 8'ha5);
    repeat (20) @(posedge sys_clk);
    #2;
    cmp_bit("busy", 1'b0, prog_busy);
    wp = 1'b0;
    write_run(11'h7f5, 1, 8'h5a);
    wait_prog();
  endtask : t_protect

  // One-byte page load cut off by the soft-reset sequence
  task automatic t_recover();
    set_ptr(11'h7f8);
    wr(8'h00, 1'b0);
    bus_op(see_pkg::SEE_OP_RECOVER);
    wr({CLASS, 4'h1}, 1'b0);
    do_cmd(see_pkg::SEE_OP_READ, 8'h00, 1'b0);
    bus_op(see_pkg::SEE_OP_STOP);
    repeat (20) @(posedge sys_clk);
    #2;
    cmp_bit("busy", 1'b0, prog_busy);
  endtask : t_recover

  // Sequential row read, then current read wrapping to zero
  task automatic t_read();
    set_ptr(11'h7f0);
    bus_op(see_pkg::SEE_OP_START);
    wr({CLASS, 4'h1}, 1'b0);
    for (int i = 0; i < 16; i++) rd(i != 15, mem[11'h7f0 + 11'(i)]);
    bus_op(see_pkg::SEE_OP_STOP);
    repeat (6) @(posedge sys_clk);
    #2;
    cmp_bit("standby", 1'b1, standby);
    bus_op(see_pkg::SEE_OP_START);
    wr({CLASS, 4'h1}, 1'b0);
    rd(1'b0, mem[0]);
    bus_op(see_pkg::SEE_OP_STOP);
  endtask : t_read

  task automatic t_bad_class();
    bus_op(see_pkg::SEE_OP_START);
    wr({CLASS ^ 4'h1, 4'h0}, 1'b1);
    bus_op(see_pkg::SEE_OP_STOP);
    cmp_bit("standby", 1'b1, standby);
  endtask : t_bad_class

  // Main sequence
  initial begin
    sys_clk    = 1'b0;
    rst_b      = 1'b0;
    wp         = 1'b0;
    cmd_valid  = 1'b0;
    cmd_op     = see_pkg::SEE_OP_START;
    cmd_data   = 8'h00;
    cmd_ack    = 1'b0;
    fail_count = 0;
    checks     = 0;
    cyc        = 0;
    repeat (4) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    cmp_bit("standby", 1'b1, standby);
    t_write();
    t_protect();
    t_recover();
    t_read();
    t_bad_class();
    give_verdict();
  end
endmodule : serial_eeprom_slave_tb
